// *** rtl/fes_pkg.sv ***
/*
 * Shared constants and carrier types for the flash error status and ECC report block.
 * Assumes a 40 MHz core clock and a command interpreter that delivers decoded one-cycle events.
 */
package fes_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int PROT_BUSY_MIN_US = 20;
	localparam int PROT_BUSY_MAX_US = 100;
	localparam int PROT_BUSY_MIN_CYC = PROT_BUSY_MIN_US * CLK_MHZ;
	localparam int PROT_BUSY_MAX_CYC = PROT_BUSY_MAX_US * CLK_MHZ;
	localparam int STALL_LIMIT_CYC = 32;

	// ------------------------------------------------------------
	// status word bit positions
	// ------------------------------------------------------------
	localparam int SW_READY = 7;
	localparam int SW_ESUSP = 6;
	localparam int SW_ERASE = 5;
	localparam int SW_PROG = 4;
	localparam int SW_ABORT = 3;
	localparam int SW_PSUSP = 2;
	localparam int SW_PROT = 1;
	localparam logic [7:0] STATUS_RESET = 8'h80;

	// ------------------------------------------------------------
	// ecc unit status word
	// ------------------------------------------------------------
	localparam int ECC_OFF = 0;
	localparam int ECC_DATA = 1;
	localparam int ECC_CODE = 2;
	localparam int ECC_CORR = 3;
	localparam int ECC_DBL = 4;
	localparam logic [15:0] ECC_STATUS_RESET = 16'h0000;
	localparam int ADDR_W = 26;

	typedef enum logic [1:0] {
		FES_OP_PROGRAM,
		FES_OP_ERASE,
		FES_OP_BLANK,
		FES_OP_PASSWORD
	} fes_op_e;

	// decoded command events, one-cycle pulses
	typedef struct packed {
		logic status_read;
		logic status_clear;
		logic reset;
		logic abort_reset;
		logic overlay_exit;
		logic ecc_enter;
	} fes_cmd_s;

	// result of an embedded operation, one-cycle pulse on done
	typedef struct packed {
		logic start;
		logic done;
		logic fail;
		logic prot_fail;
		logic buf_abort;
		fes_op_e op;
	} fes_op_s;

	// per half-page ecc outcome from the array read path
	typedef struct packed {
		logic valid;
		logic off;
		logic data_err;
		logic code_err;
		logic double_err;
		logic [ADDR_W-1:0] addr;
	} fes_ecc_s;

endpackage

// *** rtl/fes_top.sv ***
/*
 * Error reporting and clearing for the embedded algorithm controller, plus ECC status reporting.
 * Assumes command decode and array/ECC engines outside; the read strobe logic runs on the link clock.
 */
// Function
// - failed operation holds ready with error bits
// - error sets bit5 erase/blank, bit4 program/password
// - reset or status clear ends operation error
// - operation error accepts only read/reset/clear
// - protection violation: timed busy, abort, resume
// - protection busy shows not ready, read only
// - after busy: ready, bit1, bit5/bit4 set
// - after protection busy any command accepted
// - new program/erase clears its status bit
// - buffer abort holds bits 3,4 with ready
// - abort reset or status clear ends abort
// - abort accepts only read/abort reset/clear
// - non-status reads in algorithm give junk
// - interrupt flags one- or two-bit ECC errors
// - ECC status read returns selected unit status
// - unit bits: off, data error, code error
// - bits 4,3 global sticky until mode exit
// - two-bit event traps address, invalidates 3:1
// - status read's own ECC results set flags
// - bits 15:5 reserved, read as zero
// - hardware reset or exit zeros ECC status
// - after clear return overlay, suspend, standby
// - resets ignored while program/erase runs
// - mode exit clears the address trap
`timescale 1ns/100ps

module fes_top
	import fes_pkg::*;
#(
	parameter int PROT_BUSY_CYC = 1600
)
(
	// core clock and reset
	input wire logic clk,
	input wire logic srst,
	// decoded commands and operation results
	input wire fes_pkg::fes_cmd_s cmd,
	input wire fes_pkg::fes_op_s op,
	input wire logic overlay_active,
	input wire logic erase_suspended,
	// ecc results and configuration
	input wire fes_pkg::fes_ecc_s ecc,
	input wire logic ecc_irq_en,
	input wire logic stall_en,
	// status outputs
	output logic [7:0] status_word,
	output logic [15:0] ecc_unit_status,
	output logic [fes_pkg::ADDR_W-1:0] trap_addr,
	output logic ecc_irq_n,
	output logic array_data_valid,
	output logic resume_overlay,
	output logic resume_suspend,
	output logic cmd_accept_any,
	// link side
	input wire logic link_clk,
	input wire logic cs_n,
	input wire logic rd_active,
	output logic read_strobe
);
	import fes_pkg::*;

	// ------------------------------------------------------------
	// algorithm controller state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FES_IDLE,
		FES_BUSY,
		FES_OP_ERR,
		FES_PROT_BUSY,
		FES_ABORT
	} fes_state_e;

	fes_state_e state_q, state_d;
	logic [7:0] status_q, status_d;
	logic [15:0] busy_cnt_q, busy_cnt_d;
	logic prog_op;
	logic erase_op;
	logic clear_cmd;
	fes_op_e last_op_q, last_op_d;

	// a duration outside the printed window would break the busy contract
	localparam logic [15:0] BUSY_LOAD = (PROT_BUSY_CYC < PROT_BUSY_MIN_CYC) ? 16'(PROT_BUSY_MIN_CYC) :
		(PROT_BUSY_CYC > PROT_BUSY_MAX_CYC) ? 16'(PROT_BUSY_MAX_CYC) : 16'(PROT_BUSY_CYC);

	// failure and protection paths must sort op kinds the same way
	function automatic logic is_prog_kind(fes_op_e k);
		return (k == FES_OP_PROGRAM) || (k == FES_OP_PASSWORD);
	endfunction

	function automatic logic is_erase_kind(fes_op_e k);
		return (k == FES_OP_ERASE) || (k == FES_OP_BLANK);
	endfunction

	assign prog_op = is_prog_kind(op.op);
	assign erase_op = is_erase_kind(op.op);
	assign clear_cmd = cmd.reset || cmd.status_clear;

	always_comb
	begin
		state_d = state_q;
		status_d = status_q;
		busy_cnt_d = busy_cnt_q;
		unique case (state_q)
			FES_IDLE:
			begin
				if (op.start)
				begin
					state_d = FES_BUSY;
					status_d[SW_READY] = 1'b0;
					if (prog_op)
						status_d[SW_PROG] = 1'b0;
					if (erase_op)
						status_d[SW_ERASE] = 1'b0;
					status_d[SW_PROT] = 1'b0;
				end
				else if (cmd.status_clear)
					status_d = STATUS_RESET;
			end
			FES_BUSY:
			begin
				// resets during the running operation are dropped
				if (op.done)
				begin
					status_d[SW_PSUSP] = 1'b0;
					if (op.prot_fail)
					begin
						state_d = FES_PROT_BUSY;
						busy_cnt_d = BUSY_LOAD;
					end
					else if (op.buf_abort)
					begin
						state_d = FES_ABORT;
						status_d[SW_READY] = 1'b1;
						status_d[SW_ABORT] = 1'b1;
						status_d[SW_PROG] = 1'b1;
						status_d[SW_ERASE] = 1'b0;
						status_d[SW_PROT] = 1'b0;
					end
					else if (op.fail)
					begin
						state_d = FES_OP_ERR;
						status_d[SW_READY] = 1'b1;
						status_d[SW_ERASE] = erase_op;
						status_d[SW_PROG] = prog_op;
						status_d[SW_PROT] = 1'b0;
					end
					else
					begin
						state_d = FES_IDLE;
						status_d[SW_READY] = 1'b1;
					end
				end
			end
			FES_OP_ERR:
			begin
				if (clear_cmd)
				begin
					state_d = FES_IDLE;
					status_d = STATUS_RESET;
				end
			end
			FES_PROT_BUSY:
			begin
				// only status read is honoured; it changes nothing
				if (busy_cnt_q <= 16'h0001)
				begin
					state_d = FES_IDLE;
					status_d[SW_READY] = 1'b1;
					status_d[SW_PROT] = 1'b1;
					// op lines are idle by now, so use the kind held from start
					status_d[SW_ERASE] = is_erase_kind(last_op_q);
					status_d[SW_PROG] = is_prog_kind(last_op_q);
					status_d[SW_PSUSP] = 1'b0;
					busy_cnt_d = 16'h0000;
				end
				else
					busy_cnt_d = busy_cnt_q - 16'h0001;
			end
			FES_ABORT:
			begin
				if (cmd.abort_reset || cmd.status_clear)
				begin
					state_d = FES_IDLE;
					status_d = STATUS_RESET;
				end
			end
			default:
			begin
				state_d = FES_IDLE;
			end
		endcase
		status_d[SW_ESUSP] = erase_suspended;
	end

	// op type is held from start so the protection path knows it later
	always_comb
	begin
		last_op_d = (op.start) ? op.op : last_op_q;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= FES_IDLE;
			status_q <= STATUS_RESET;
			busy_cnt_q <= 16'h0000;
			last_op_q <= FES_OP_PROGRAM;
		end
		else
		begin
			state_q <= state_d;
			status_q <= status_d;
			busy_cnt_q <= busy_cnt_d;
			last_op_q <= last_op_d;
		end
	end

	assign status_word = status_q;
	assign cmd_accept_any = (state_q == FES_IDLE);
	// error clear returns to whichever mode was pending
	assign resume_overlay = (state_q == FES_IDLE) && overlay_active;
	assign resume_suspend = (state_q == FES_IDLE) && !overlay_active && erase_suspended;
	assign array_data_valid = (state_q == FES_IDLE);

	// ------------------------------------------------------------
	// ecc status word and trap
	// ------------------------------------------------------------
	logic [2:0] unit_q, unit_d;
	logic corr_q, corr_d;
	logic dbl_q, dbl_d;
	logic trap_vld_q, trap_vld_d;
	logic [ADDR_W-1:0] trap_q, trap_d;
	logic irq_q, irq_d;
	logic ecc_mode_q, ecc_mode_d;
	logic ecc_exit;

	// a reset outside the status overlay leaves the sticky flags alone
	assign ecc_exit = ecc_mode_q && (cmd.reset || cmd.overlay_exit);

	always_comb
	begin
		unit_d = unit_q;
		corr_d = corr_q;
		dbl_d = dbl_q;
		trap_d = trap_q;
		trap_vld_d = trap_vld_q;
		irq_d = 1'b0;
		ecc_mode_d = ecc_mode_q;
		if (ecc_exit)
		begin
			ecc_mode_d = 1'b0;
			unit_d = 3'h0;
			corr_d = 1'b0;
			dbl_d = 1'b0;
			trap_d = '0;
			trap_vld_d = 1'b0;
		end
		if (cmd.ecc_enter)
			ecc_mode_d = 1'b1;
		// status-read results also feed the sticky flags
		if (ecc.valid)
		begin
			unit_d = {ecc.code_err, ecc.data_err, ecc.off};
			if (ecc.data_err || ecc.code_err)
				corr_d = 1'b1;
			if (ecc.double_err)
			begin
				dbl_d = 1'b1;
				if (!trap_vld_q || ecc_exit)
				begin
					trap_d = ecc.addr;
					trap_vld_d = 1'b1;
				end
			end
			irq_d = ecc_irq_en && (ecc.data_err || ecc.code_err || ecc.double_err);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			unit_q <= 3'h0;
			corr_q <= 1'b0;
			dbl_q <= 1'b0;
			trap_q <= '0;
			trap_vld_q <= 1'b0;
			irq_q <= 1'b0;
			ecc_mode_q <= 1'b0;
		end
		else
		begin
			unit_q <= unit_d;
			corr_q <= corr_d;
			dbl_q <= dbl_d;
			trap_q <= trap_d;
			trap_vld_q <= trap_vld_d;
			irq_q <= irq_d;
			ecc_mode_q <= ecc_mode_d;
		end
	end

	// reserved bits read zero; bits 3:1 are not meaningful once dbl is set
	assign ecc_unit_status = {11'h000, dbl_q, corr_q, unit_q};
	assign trap_addr = trap_q;
	assign ecc_irq_n = !irq_q;

	// ------------------------------------------------------------
	// read strobe on the link clock
	// ------------------------------------------------------------
	// double-bit event crosses as a toggle
	logic dbl_tgl_q, dbl_tgl_d;
	always_comb
	begin
		dbl_tgl_d = dbl_tgl_q ^ (ecc.valid && ecc.double_err);
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			dbl_tgl_q <= 1'b0;
		else
			dbl_tgl_q <= dbl_tgl_d;
	end

	logic [2:0] tgl_sync_q;
	logic [2:0] en_sync_q;
	logic stall_armed;
	logic stalled_q, stalled_d;
	logic strobe_q, strobe_d;

	// the enable is a core-clock level: taken once the last two stages agree
	assign stall_armed = en_sync_q[2] && en_sync_q[1];

	always_comb
	begin
		stalled_d = stalled_q;
		// the host flags a bus error after more than 32 idle strobe clocks
		if (tgl_sync_q[2] != tgl_sync_q[1] && stall_armed)
			stalled_d = 1'b1;
		strobe_d = rd_active && !stalled_d && !strobe_q;
	end

	// chip select ends the frame; release is asynchronous to the stopped link clock
	always_ff @(posedge link_clk or posedge cs_n)
	begin
		if (cs_n)
		begin
			stalled_q <= 1'b0;
			strobe_q <= 1'b0;
		end
		else
		begin
			stalled_q <= stalled_d;
			strobe_q <= strobe_d;
		end
	end

	always_ff @(posedge link_clk)
	begin
		tgl_sync_q <= {tgl_sync_q[1:0], dbl_tgl_q};
		// stages only move while the link clock runs; an event between frames shows at the next frame
		en_sync_q <= {en_sync_q[1:0], stall_en};
	end

	assign read_strobe = strobe_q;

endmodule

// *** tb/fes_asserts.sv ***
/*
 * Checker for fes_top: status word and ECC word relations in time.
 * Assumes it is bound to fes_top and sees only its ports.
 */
`timescale 1ns/100ps
module fes_asserts
	import fes_pkg::*;
#(
	parameter int PROT_BUSY_CYC = 1600
)
(
	// core clock and reset
	input wire logic clk,
	input wire logic srst,
	// block inputs
	input wire fes_pkg::fes_cmd_s cmd,
	input wire fes_pkg::fes_op_s op,
	input wire fes_pkg::fes_ecc_s ecc,
	input wire logic ecc_irq_en,
	// block outputs
	input wire logic [7:0] status_word,
	input wire logic [15:0] ecc_unit_status,
	input wire logic [fes_pkg::ADDR_W-1:0] trap_addr,
	input wire logic ecc_irq_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic op_err;
	logic clr;
	logic fail_now;
	logic ecc_mode_q;
	int busy_q;
	assign op_err = status_word[7] && status_word[5:4] != 2'b00 && !status_word[3] && !status_word[1];
	assign clr = cmd.reset || cmd.status_clear;
	assign fail_now = op.done && op.fail && !op.prot_fail && !op.buf_abort;
	// not-ready run length counted from the protection verdict
	always_ff @(posedge clk)
	begin
		busy_q <= (status_word[7] || (op.done && op.prot_fail)) ? 0 : busy_q + 1;
		ecc_mode_q <= !srst && (cmd.ecc_enter || (ecc_mode_q && !cmd.reset && !cmd.overlay_exit));
	end
	a_fail_bits: assert property (fail_now |=> status_word[7] && status_word[2:1] == 2'b00 &&
		status_word[5:4] == (($past(op.op) inside {FES_OP_ERASE, FES_OP_BLANK}) ? 2'b10 : 2'b01))
		else $error("failure bits wrong");
	a_err_refuse: assert property (op_err && !clr && !op.start |=> status_word[5:4] == $past(status_word[5:4]))
		else $error("error left without clear");
	a_err_clear: assert property (op_err && clr |=> status_word[7] && status_word[5:1] == 5'h00)
		else $error("error not cleared");
	a_prot_busy: assert property (op.done && op.prot_fail |=> (!status_word[7]) [*8])
		else $error("protection busy not shown");
	a_prot_end: assert property ($rose(status_word[7]) && status_word[1] |-> busy_q >= PROT_BUSY_MIN_CYC
		&& busy_q <= PROT_BUSY_MAX_CYC && (busy_q == PROT_BUSY_CYC || PROT_BUSY_CYC < PROT_BUSY_MIN_CYC
		|| PROT_BUSY_CYC > PROT_BUSY_MAX_CYC) && !status_word[2] && (status_word[5] ^ status_word[4]))
		else $error("protection busy length or bits wrong");
	a_abort_hold: assert property (status_word[3] && !cmd.abort_reset && !cmd.status_clear |=>
		status_word[7] && status_word[5:1] == 5'h0C) else $error("abort not held");
	a_abort_clear: assert property (status_word[3] && (cmd.abort_reset || cmd.status_clear) |=>
		status_word[7] && status_word[5:1] == 5'h00) else $error("abort not cleared");
	a_irq_pulse: assert property (ecc.valid && ecc_irq_en && (ecc.data_err || ecc.code_err || ecc.double_err)
		|=> !ecc_irq_n) else $error("ecc interrupt missing");
	a_ecc_exit: assert property (ecc_mode_q && (cmd.reset || cmd.overlay_exit) && !ecc.valid && status_word[7]
		&& !status_word[3] |=> ecc_unit_status == 16'h0000 && trap_addr == '0) else $error("ecc exit kept state");
endmodule

bind fes_top fes_asserts #(.PROT_BUSY_CYC(PROT_BUSY_CYC)) u_fes_asserts (.clk(clk), .srst(srst), .cmd(cmd),
	.op(op), .ecc(ecc), .ecc_irq_en(ecc_irq_en), .status_word(status_word), .ecc_unit_status(ecc_unit_status),
	.trap_addr(trap_addr), .ecc_irq_n(ecc_irq_n));

// *** tb/fes_host_model.sv ***
/*
 * Host reader on the link: opens a read frame on request and times the read strobe.
 * Assumes the bench gates the link clock with the frame select.
 */
`timescale 1ns/100ps
module fes_host_model
(
	// link clock and bench request
	input wire logic link_clk,
	input wire logic frame_req,
	input wire logic read_strobe,
	// link outputs
	output logic cs_n,
	output logic rd_active,
	output logic bus_error
);
	logic last_q;
	int quiet_q;
	assign cs_n = !frame_req;
	initial {rd_active, bus_error} = 2'h0;
	// a strobe standing still too long is a bus error, not a slow device
	always @(posedge link_clk or posedge cs_n)
	begin
		if (cs_n)
		begin
			rd_active <= 1'b0;
			quiet_q <= 0;
			bus_error <= 1'b0;
		end
		else
		begin
			rd_active <= 1'b1;
			last_q <= read_strobe;
			quiet_q <= (read_strobe !== last_q) ? 0 : quiet_q + 1;
			if (quiet_q > 32) bus_error <= 1'b1;
		end
	end
endmodule

// *** tb/testbench.sv ***
/*
 * Testbench for fes_top: operation results, commands and ECC events; a host model reads on the link.
 * Assumes the hand-over timing of fes_top.
 */
`timescale 1ns/100ps
module testbench;
	import fes_pkg::*;
	logic clk, lk, srst, overlay_active, erase_suspended, ecc_irq_en, stall_en, frame_req;
	logic cs_n, rd_active, bus_error, ecc_irq_n, array_data_valid, resume_overlay, cmd_accept_any, read_strobe;
	logic resume_suspend;
	fes_cmd_s cmd;
	fes_op_s op;
	fes_ecc_s ecc;
	logic [7:0] status_word;
	logic [15:0] ecc_unit_status;
	logic [ADDR_W-1:0] trap_addr;
	int fail_count = 0;
	int n_compared = 0;
	wire link_clk = lk & ~cs_n;
	fes_top #(.PROT_BUSY_CYC(800)) DUT (.clk(clk), .srst(srst), .cmd(cmd), .op(op), .overlay_active(overlay_active),
		.erase_suspended(erase_suspended), .ecc(ecc), .ecc_irq_en(ecc_irq_en), .stall_en(stall_en),
		.status_word(status_word), .ecc_unit_status(ecc_unit_status), .trap_addr(trap_addr), .ecc_irq_n(ecc_irq_n),
		.array_data_valid(array_data_valid), .resume_overlay(resume_overlay), .resume_suspend(resume_suspend),
		.cmd_accept_any(cmd_accept_any), .link_clk(link_clk), .cs_n(cs_n), .rd_active(rd_active),
		.read_strobe(read_strobe));
	fes_host_model host (.link_clk(link_clk), .frame_req(frame_req), .read_strobe(read_strobe), .cs_n(cs_n),
		.rd_active(rd_active), .bus_error(bus_error));
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// link clock unrelated in phase, gated to frames
	initial
	begin
		lk = 0;
		#7;
		forever #32 lk = ~lk;
	end
	task automatic tick(int n = 1);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic send(logic [5:0] c);
		cmd <= c;
		tick;
		cmd <= '0;
		tick(2);
	endtask
	task automatic run(fes_op_e t, logic [2:0] r);
		op <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, t};
		tick;
		op <= '{1'b0, 1'b1, r[2], r[1], r[0], t};
		tick;
		op <= '0;
		tick(2);
	endtask
	// k is off, data, code, double; bits 3:1 are invalid after a double error
	task automatic hit(logic [3:0] k, logic [25:0] a, logic [15:0] e);
		ecc <= '{1'b1, k[3], k[2], k[1], k[0], a};
		tick;
		ecc <= '0;
		#1;
		chk("irq_n", !(ecc_irq_en && |k[2:0]), ecc_irq_n);
		tick(2);
		chk("ecc", e, ecc_unit_status & (k[0] ? 16'hFFF1 : 16'hFFFF));
	endtask
	initial
	begin
		{cmd, op, ecc} = '0;
		{overlay_active, erase_suspended, ecc_irq_en, stall_en, frame_req} = '0;
		srst = 1;
		tick(5);
		srst <= 0;
		tick(2);
		chk("ecc", 16'h0000, ecc_unit_status);
		for (int i = 0; i < 4; i++)
		begin
			overlay_active <= (i == 3);
			run(fes_op_e'(i), 3'b100);
			run(FES_OP_PROGRAM, 3'b000);
			send(6'h20);
			chk("status", (i == 1 || i == 2) ? 8'hA0 : 8'h90, status_word);
			send(i[0] ? 6'h10 : 6'h08);
			chk("status", 8'h80, status_word);
			chk("resume", i == 3, resume_overlay);
		end
		overlay_active <= 0;
		for (int i = 0; i < 2; i++)
		begin
			run(fes_op_e'(i), 3'b010);
			send(6'h08);
			chk("busy", 8'h00, {status_word[7], 6'h00, array_data_valid});
			for (int k = 0; k < 5000 && status_word[7] !== 1'b1; k++) tick;
			tick(2);
			chk("status", i ? 8'hA2 : 8'h92, status_word);
			chk("accept", 1, cmd_accept_any);
			run(fes_op_e'(i), 3'b000);
			chk("status", 8'h80, status_word);
		end
		for (int i = 0; i < 2; i++)
		begin
			run(FES_OP_PROGRAM, 3'b001);
			send(6'h20);
			send(6'h08);
			chk("status", 8'h98, status_word);
			send(i ? 6'h10 : 6'h04);
			chk("status", 8'h80, status_word);
		end
		erase_suspended <= 1;
		tick(2);
		chk("status", 8'hC0, status_word);
		chk("resume", 1, resume_suspend);
		erase_suspended <= 0;
		ecc_irq_en <= 1;
		stall_en <= 1;
		frame_req <= 1;
		send(6'h01);
		hit(4'h4, 26'h0, 16'h000A);
		hit(4'h8, 26'h0, 16'h0009);
		ecc_irq_en <= 0;
		hit(4'h2, 26'h0, 16'h000C);
		ecc_irq_en <= 1;
		tick(90);
		chk("bus_err", 0, bus_error);
		hit(4'h1, 26'h0ABCDE, 16'h0010);
		chk("trap", 26'h0ABCDE, trap_addr);
		// sync stages plus 33 quiet link clocks must fit in this wait
		tick(120);
		chk("bus_err", 1, bus_error);
		chk("strobe", 0, read_strobe);
		frame_req <= 0;
		send(6'h02);
		chk("ecc", 0, ecc_unit_status);
		chk("trap", 0, trap_addr);
		summarize;
	end
	initial
	begin
		tick(30000);
		fail_count++;
		summarize;
	end
endmodule
